// ===== dv/interval_timer_monitor.sv
// Purpose: port-level checks of the interval timer
// Assumes: zero-wait apb; the count is not visible at the ports
// Notes: bound to every instance of the timer
module interval_timer_monitor (
  // apb
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // events
  input wire clock_gated,
  input wire irq,
  input wire [7:0] irq_vector,
  input wire wake_up
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire mapped = (paddr[11:4] == 8'h36) && (paddr[1:0] == 2'b00);
  sequence s_acc; psel && penable; endsequence
  sequence s_rd; s_acc ##0 !pwrite; endsequence
  property p_vec; irq_vector == 8'h08; endproperty
  a_vec: assert property (p_vec) else $error("bad irq vector");
  property p_rdy; psel |-> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("pready low");
  property p_err; s_acc |-> pslverr == !mapped; endproperty
  a_err: assert property (p_err) else $error("pslverr wrong");
  property p_rdz; s_rd ##0 pslverr |-> prdata == 32'h0; endproperty
  a_rdz: assert property (p_rdz) else $error("unmapped read not zero");
  property p_mode; s_rd ##0 (paddr == 12'h360) |-> prdata[3:0] == 4'h0; endproperty
  a_mode: assert property (p_mode) else $error("mode low bits set");
  property p_wgate; $rose(wake_up) |-> $past(clock_gated); endproperty
  a_wgate: assert property (p_wgate) else $error("wake while not gated");
  property p_wpulse; wake_up |=> !wake_up; endproperty
  a_wpulse: assert property (p_wpulse) else $error("wake too long");
  property p_ifall; $fell(irq) |-> $past(psel && penable && pwrite); endproperty
  a_ifall: assert property (p_ifall) else $error("irq dropped by itself");
endmodule
bind interval_timer interval_timer_monitor interval_timer_monitor_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .clock_gated(clock_gated), .irq(irq), .irq_vector(irq_vector), .wake_up(wake_up));

// ===== dv/interval_timer_tb.sv
// Purpose: self-checking bench of the interval timer
// Assumes: cpu_tick high every cycle, every other cycle in the last pass
// Notes: count seen only by read-back
`include "interval_timer_defs.vh"
module interval_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, cpu_tick, clock_gated, err, half_rate;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd, c;
  wire [31:0] prdata;
  wire pready, pslverr, irq, wake_up;
  wire [7:0] irq_vector;
  int error_cnt, checked, wakes, exp_w, n, k, t, m;
  interval_timer interval_timer_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu_tick(cpu_tick), .clock_gated(clock_gated), .irq(irq), .irq_vector(irq_vector), .wake_up(wake_up));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) if (wake_up === 1'b1) wakes++;
  // half rate instruction cycles show the prescaler counts cpu_tick, not pclk
  always @(posedge pclk) cpu_tick <= half_rate ? ~cpu_tick : 1'b1;
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chkb(input logic g, input logic e);
    chk({31'h0, g}, {31'h0, e});
  endtask
  // release edge kept so back-to-back calls never drive psel twice in a step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
    @(posedge pclk);
  endtask
  task automatic print_verdict;
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    print_verdict;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, clock_gated, half_rate} = '0;
    k = $urandom(32'he572);
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 12'h360 + 12'(4 * i), 32'h0);
      chk(rd, 32'h0);
    end
    apb(1'b0, 12'h370, 32'h0);
    chkb(err, 1'b1);
    apb(1'b1, `MODE_CONTROL_ADDR, 32'h7f);
    apb(1'b0, `MODE_CONTROL_ADDR, 32'h0);
    chk(rd, 32'h70);
    apb(1'b0, `COUNT_VALUE_ADDR, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, `IRQ_MASK_ADDR, 32'h1);
    for (int s = 0; s < 8; s++) begin
      n = 256 >> s;
      k = 1 + $urandom % 3;
      m = (s == 7) ? 2 : 1;
      half_rate <= (s == 7);
      clock_gated <= s[0];
      exp_w += s[0];
      apb(1'b1, `MODE_CONTROL_ADDR, {25'h0, s[2:0], 4'h0});
      apb(1'b1, `COUNT_VALUE_ADDR, {24'h0, 8'(256 - k)});
      apb(1'b1, `IRQ_STATUS_ADDR, 32'h1);
      apb(1'b1, `MODE_CONTROL_ADDR, {25'h1, s[2:0], 4'h0});
      repeat (k * n * m - m + 1) @(posedge pclk);
      chkb(irq, 1'b0);
      for (t = 0; irq !== 1'b1 && t < 12; t++) @(posedge pclk);
      chkb(irq, 1'b1);
      apb(1'b1, `MODE_CONTROL_ADDR, {25'h0, s[2:0], 4'h0});
      chk(wakes, exp_w);
      apb(1'b0, `COUNT_VALUE_ADDR, 32'h0);
      c = rd;
      chkb(c <= 32'h2, 1'b1);
      repeat (20) @(posedge pclk);
      apb(1'b0, `COUNT_VALUE_ADDR, 32'h0);
      chk(rd, c);
      chkb(irq, 1'b1);
      apb(1'b1, `IRQ_MASK_ADDR, 32'h0);
      chkb(irq, 1'b0);
      apb(1'b1, `IRQ_MASK_ADDR, 32'h1);
      chkb(irq, 1'b1);
      apb(1'b1, `IRQ_STATUS_ADDR, 32'h1);
      chkb(irq, 1'b0);
    end
    print_verdict;
  end
endmodule

// ===== verilog/interval_timer.v
// Purpose: 8-bit up-counting interval timer with prescaler, overflow flag, interrupt and wake-up
// Assumes: apb slave, zero wait states; cpu_tick marks instruction cycles
// Notes: no reload buffer; software reloads the count after each overflow
`include "interval_timer_defs.vh"

module interval_timer (
  // apb
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // system
  input wire cpu_tick,
  input wire clock_gated,
  // events
  output wire irq,
  output wire [7:0] irq_vector,
  output reg wake_up
);

  reg [7:0] mode_control;
  reg [7:0] count_value;
  reg overflow_request_flag;
  reg overflow_irq_enable;
  reg run_d;
  wire timer_tick;
  wire timer_run_enable;
  wire [2:0] prescale_select;
  wire overflow;
  wire count_wr;
  wire count_step;
  wire wr;
  wire rd;
  wire mapped;

  assign timer_run_enable = mode_control[`RUN_ENABLE_BIT];
  assign prescale_select = mode_control[`PRESCALE_HI:`PRESCALE_LO];

  assign wr = psel && penable && pwrite;
  assign rd = psel && !pwrite;
  assign mapped = (paddr == `MODE_CONTROL_ADDR) || (paddr == `COUNT_VALUE_ADDR) ||
                  (paddr == `IRQ_STATUS_ADDR) || (paddr == `IRQ_MASK_ADDR);
  assign pready = 1'b1;
  // unmapped access answers with an error, writes are dropped
  assign pslverr = psel && penable && !mapped;

  prescale_divider #(
    .WIDTH(`PRESCALE_WIDTH)
  ) u_div (
    .pclk(pclk),
    .presetn(presetn),
    .run(timer_run_enable),
    .restart(timer_run_enable && !run_d),
    .cpu_tick(cpu_tick),
    .prescale_select(prescale_select),
    .timer_tick(timer_tick)
  );

  // a late tick after run drops, or one lost to a count write, must not flag a wrap
  assign count_wr = wr && (paddr == `COUNT_VALUE_ADDR);
  assign count_step = timer_tick && timer_run_enable && !count_wr;
  assign overflow = count_step && (count_value == `COUNT_FULL);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_d <= 1'b0;
    end else begin
      run_d <= timer_run_enable;
    end
  end

  // mode register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_control <= `MODE_CONTROL_RESET;
    end else if (wr && paddr == `MODE_CONTROL_ADDR) begin
      mode_control <= pwdata[7:0] & `MODE_CONTROL_MASK;
    end
  end

  // counter; a same-cycle software write wins over the tick
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_value <= `COUNT_VALUE_RESET;
    end else if (count_wr) begin
      count_value <= pwdata[7:0];
    end else if (count_step) begin
      count_value <= count_value + 8'h01;
    end
  end

  // flag and mask; set wins over write-one-to-clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_request_flag <= 1'b0;
      overflow_irq_enable <= 1'b0;
    end else begin
      if (overflow) begin
        overflow_request_flag <= 1'b1;
      end else if (wr && paddr == `IRQ_STATUS_ADDR && pwdata[`OVF_FLAG_BIT]) begin
        overflow_request_flag <= 1'b0;
      end
      if (wr && paddr == `IRQ_MASK_ADDR) begin
        overflow_irq_enable <= pwdata[`OVF_FLAG_BIT];
      end
    end
  end

  assign irq = overflow_request_flag && overflow_irq_enable;
  assign irq_vector = `IRQ_VECTOR_ADDR;

  // wake pulse only meaningful while clocks are gated; counting never stops while gated
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_up <= 1'b0;
    end else begin
      wake_up <= overflow && clock_gated;
    end
  end

  // read data registered in setup phase, valid during access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd && !penable) begin
      case (paddr)
        `MODE_CONTROL_ADDR: prdata <= {24'h000000, mode_control};
        `COUNT_VALUE_ADDR: prdata <= {24'h000000, count_value};
        `IRQ_STATUS_ADDR: prdata <= {31'h0, overflow_request_flag};
        `IRQ_MASK_ADDR: prdata <= {31'h0, overflow_irq_enable};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

endmodule

// ===== verilog/interval_timer_defs.vh
// Purpose: offsets, field positions, reset values and divider width of the interval timer
// Assumes: apb byte addresses; 8-bit registers in the low bits of a 32-bit word
// Notes: definitions only
`ifndef INTERVAL_TIMER_DEFS_VH
`define INTERVAL_TIMER_DEFS_VH

// register indices as printed; byte address is four times the index
`define MODE_CONTROL_IDX 8'hd8
`define COUNT_VALUE_IDX 8'hd9
`define IRQ_STATUS_IDX 8'hda
`define IRQ_MASK_IDX 8'hdb
`define MODE_CONTROL_ADDR 12'h360
`define COUNT_VALUE_ADDR 12'h364
`define IRQ_STATUS_ADDR 12'h368
`define IRQ_MASK_ADDR 12'h36c

// mode_control fields
`define RUN_ENABLE_BIT 7
`define PRESCALE_HI 6
`define PRESCALE_LO 4
`define MODE_CONTROL_RESET 8'h00
`define MODE_CONTROL_MASK 8'hf0
`define COUNT_VALUE_RESET 8'h00

// interrupt status / mask fields
`define OVF_FLAG_BIT 0
`define IRQ_VECTOR_ADDR 8'h08

`define COUNT_FULL 8'hff
`define COUNT_ZERO 8'h00
`define PRESCALE_WIDTH 8

`endif

// ===== verilog/prescale_divider.v
// Purpose: instruction-clock prescaler producing a one-cycle tick
// Assumes: cpu_tick is a one-cycle enable at the instruction rate
// Notes: restart clears the divider so the next period is full length
`include "interval_timer_defs.vh"

module prescale_divider #(
  parameter WIDTH = `PRESCALE_WIDTH
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // control
  input wire run,
  input wire restart,
  input wire cpu_tick,
  input wire [2:0] prescale_select,
  // result
  output reg timer_tick
);

  reg [WIDTH-1:0] div_count;
  wire [WIDTH-1:0] next_div_count;
  reg [WIDTH-1:0] terminal;

  // code 000 divides by 256, 111 by 2
  always @* begin
    terminal = {WIDTH{1'b1}} >> prescale_select;
  end

  assign next_div_count = (div_count == terminal) ? {WIDTH{1'b0}} : div_count + 1'b1;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_count <= {WIDTH{1'b0}};
      timer_tick <= 1'b0;
    end else if (restart || !run) begin
      div_count <= {WIDTH{1'b0}};
      timer_tick <= 1'b0;
    end else if (cpu_tick) begin
      div_count <= next_div_count;
      timer_tick <= (div_count == terminal);
    end else begin
      timer_tick <= 1'b0;
    end
  end

endmodule
